// *** hdl/sbcwd_pkg.sv ***
/*
 * sbcwd_pkg: shared constants and types of the watchdog init configuration block.
 * Assumes a 200 MHz system clock and 8-bit or 16-bit SPI frames already assembled upstream.
 */
package sbcwd_pkg;
    // frame layout: [15:14] access, [13:9] address, [8] parity, [7:0] data
    localparam logic [1:0] WR_ACCESS = 2'h1;
    localparam logic [4:0] CFG_ADDR = 5'h06;
    localparam logic [6:0] REFRESH_HDR = 7'h00;
    localparam logic [7:0] CFG_RESET = 8'h42;
    localparam logic [7:0] LFSR_SEED = 8'h5a;
    localparam logic [7:0] LFSR_TAPS = 8'hb8;
    // field positions inside the configuration byte
    localparam int B_DEADLINE = 7;
    localparam int B_OCSEL_HI = 6;
    localparam int B_OCSEL_LO = 5;
    localparam int B_SAFE = 4;
    localparam int B_SCHEME_HI = 3;
    localparam int B_SCHEME_LO = 2;
    localparam int B_WINDOW = 1;
    localparam int B_CRANK = 0;
    // timing
    localparam int CLK_MHZ = 200;
    localparam int OC_FILT_US = 100;
    localparam int OC_FILT_CYC = OC_FILT_US * CLK_MHZ;
    localparam int RST_PULSE_NS = 1000;
    localparam int RST_PULSE_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int WD_PERIOD_US = 10000;
    localparam int WD_PERIOD_CYC = WD_PERIOD_US * CLK_MHZ;
    localparam logic [1:0] IRQ_FULL_PERIODS = 2'h2;

    typedef enum logic [1:0] {
        SCH_SIMPLE = 2'b00,
        SCH_ONE = 2'b01,
        SCH_TWO = 2'b10,
        SCH_FOUR = 2'b11
    } sbcwd_scheme_type;

    typedef enum logic [0:0] {
        RS_RUN = 1'b0,
        RS_PULSE = 1'b1
    } sbcwd_rst_state_type;
endpackage : sbcwd_pkg

// *** hdl/sbcwd_core.sv ***
/*
 * sbcwd_core: watchdog init configuration register and the watchdog it steers.
 * Assumes frames arrive from the SPI receiver on clk_in as one-cycle strobes;
 * overcurrent and supply-low comparators are asynchronous and synchronised here.
 */
// Summary of operation
// - configuration register is writable only in initialisation mode.
// - written by 16-bit frame, address 0_0110 plus parity bit, data byte second.
// - deadline bit clear means no limit on reading the interrupt source.
// - deadline bit set: read within rest of period plus two periods, else fail.
// - low-power without watchdog, overcurrent select 00 or 01 ignores overcurrent.
// - low-power without watchdog, select 10: overcurrent over 100 us wakes.
// - low-power without watchdog, select 11: overcurrent over programmed time wakes.
// - low-power with watchdog, select 00 or 01 ignores overcurrent; refresh by SPI.
// - low-power with watchdog, select 10: overcurrent over 100 us wakes.
// - low-power with watchdog, select 11: short overcurrent refreshes, long one wakes.
// - fail-safe bit clear: fail-safe output falls with the first reset.
// - fail-safe bit set: fail-safe output falls at second consecutive reset.
// - scheme 00 is simple refresh, 8-bit or 16-bit frame accepted.
// - scheme 01 needs one 16-bit frame carrying the random code.
// - scheme 10 needs two coded 16-bit frames; only the pair refreshes.
// - scheme 11 needs four coded 16-bit frames; only the full set refreshes.
// - window bit clear: timeout mode, refresh accepted anywhere in period.
// - window bit set: refresh only in second half of the period.
// - crank bit clear: supply low turns main regulator off and resets.
// - crank bit set: main regulator stays on with supply low.
// - first-byte bit 0 is checked as parity on configuration writes only, when parity use is enabled.
`timescale 1ns/1ps
module sbcwd_core
    import sbcwd_pkg::*;
#(
    parameter int WD_PERIOD = WD_PERIOD_CYC,
    parameter int OC_FILT = OC_FILT_CYC,
    parameter int RST_PULSE = RST_PULSE_CYC
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic frame_valid_in,
    input wire logic frame_len16_in,
    input wire logic [15:0] frame_data_in,
    input wire logic parity_en_in,
    input wire logic init_mode_in,
    input wire logic low_power_regulator_on_mode_in,
    input wire logic wd_in_lp_in,
    input wire logic overcurrent_in,
    input wire logic supply_low_in,
    input wire logic [23:0] overcurrent_wake_time_in,
    input wire logic irq_event_in,
    input wire logic irq_read_in,
    output logic [7:0] cfg_out,
    output logic [7:0] random_code_out,
    output logic rst_n_out,
    output logic safe_n_out,
    output logic vdd_en_out,
    output logic wake_out
);
    if (WD_PERIOD < 4 || WD_PERIOD >= 2 ** 24 || OC_FILT < 2 || OC_FILT >= 2 ** 24
        || RST_PULSE < 1 || RST_PULSE >= 2 ** 16) begin : g_bad_param
        $error("sbcwd_core: parameter out of range");
    end

    localparam logic [23:0] PER_LAST = 24'(WD_PERIOD - 1);
    localparam logic [23:0] PER_HALF = 24'(WD_PERIOD / 2);
    localparam logic [23:0] OC_LAST = 24'(OC_FILT - 1);
    localparam logic [15:0] RST_LAST = 16'(RST_PULSE - 1);

    // odd parity over the whole frame when enabled
    function automatic logic parity_ok(input logic [15:0] f, input logic en);
        parity_ok = !en || (^f);
    endfunction : parity_ok

    // last frame index of a coded refresh sequence
    function automatic logic [1:0] seq_last(input sbcwd_scheme_type s);
        case (s)
            SCH_TWO: seq_last = 2'h1;
            SCH_FOUR: seq_last = 2'h3;
            default: seq_last = 2'h0;
        endcase
    endfunction : seq_last

    logic [1:0] sync1_r;
    logic [1:0] sync2_r;
    logic [7:0] cfg_r, cfg_nxt;
    logic [7:0] lfsr_r, lfsr_nxt;
    logic [7:0] code_r, code_nxt;
    logic [23:0] per_cnt_r, per_cnt_nxt;
    logic [1:0] seq_r, seq_nxt;
    logic irq_pend_r, irq_pend_nxt;
    logic [1:0] irq_ends_r, irq_ends_nxt;
    logic [23:0] oc_cnt_r, oc_cnt_nxt;
    logic oc_woke_r, oc_woke_nxt;
    sbcwd_rst_state_type st_r, st_nxt;
    logic [15:0] rcnt_r, rcnt_nxt;
    logic strike_r, strike_nxt;
    logic safe_n_r, safe_n_nxt;
    logic rst_n_r, rst_n_nxt;
    logic vdd_en_r, vdd_en_nxt;
    logic wake_r, wake_nxt;

    logic oc_s, vlow_s, wr_cfg, rf, wd_active, in_window, code_ok, crank_rst;
    logic bad, timeout, refresh_done, per_end, deadline_fail, fail, oc_refresh, lp_oc;
    sbcwd_scheme_type scheme;
    logic [1:0] oc_sel;

    assign oc_s = sync2_r[0];
    assign vlow_s = sync2_r[1];
    assign scheme = sbcwd_scheme_type'(cfg_r[B_SCHEME_HI:B_SCHEME_LO]);
    assign oc_sel = cfg_r[B_OCSEL_HI:B_OCSEL_LO];

    // frame decode and watchdog events
    always_comb begin
        wr_cfg = frame_valid_in && frame_len16_in && frame_data_in[15:14] == WR_ACCESS
            && frame_data_in[13:9] == CFG_ADDR && parity_ok(frame_data_in, parity_en_in)
            && init_mode_in;
        rf = frame_valid_in && frame_data_in[15:9] == REFRESH_HDR;
        wd_active = !init_mode_in && (!low_power_regulator_on_mode_in || wd_in_lp_in) && st_r == RS_RUN;
        in_window = !cfg_r[B_WINDOW] || per_cnt_r >= PER_HALF;
        code_ok = frame_len16_in && frame_data_in[7:0] == (code_r ^ {6'h00, seq_r});
        lp_oc = low_power_regulator_on_mode_in && oc_sel[1];
        // short overcurrent ending before the programmed time acts as a refresh
        oc_refresh = lp_oc && wd_in_lp_in && oc_sel[0] && !oc_s && oc_cnt_r != 24'h0000
            && !oc_woke_r && wd_active;
        bad = rf && wd_active && (!in_window || (scheme != SCH_SIMPLE && !code_ok));
        refresh_done = (rf && wd_active && in_window
            && (scheme == SCH_SIMPLE || (code_ok && seq_r == seq_last(scheme))))
            || oc_refresh;
        timeout = wd_active && per_cnt_r == PER_LAST && !refresh_done;
        per_end = timeout || refresh_done;
        deadline_fail = cfg_r[B_DEADLINE] && irq_pend_r && per_end
            && irq_ends_r == IRQ_FULL_PERIODS && !irq_read_in;
        fail = bad || timeout || deadline_fail;
        crank_rst = vlow_s && !cfg_r[B_CRANK];
    end

    // next state of registers, counters and outputs
    always_comb begin
        cfg_nxt = wr_cfg ? frame_data_in[7:0] : cfg_r;
        lfsr_nxt = {lfsr_r[6:0], ^(lfsr_r & LFSR_TAPS)};
        code_nxt = refresh_done ? lfsr_r : code_r; // fresh code after every good refresh
        per_cnt_nxt = (per_end || !wd_active) ? 24'h0000 : per_cnt_r + 24'h0001;
        seq_nxt = seq_r;
        if (!wd_active || refresh_done || bad || timeout) begin
            seq_nxt = 2'h0;
        end else if (rf && scheme != SCH_SIMPLE && code_ok) begin
            seq_nxt = seq_r + 2'h1;
        end
        // interrupt read deadline: a new event wins over a read in the same cycle
        irq_pend_nxt = irq_pend_r;
        irq_ends_nxt = irq_ends_r;
        if (irq_event_in && !irq_pend_r) begin
            irq_pend_nxt = 1'b1;
            irq_ends_nxt = 2'h0;
        end else if (irq_read_in || deadline_fail) begin
            irq_pend_nxt = irq_event_in;
            irq_ends_nxt = 2'h0;
        end else if (irq_pend_r && per_end && irq_ends_r != IRQ_FULL_PERIODS) begin
            irq_ends_nxt = irq_ends_r + 2'h1;
        end
        // overcurrent filter; limit is 100 us for 10, programmed time for 11
        oc_cnt_nxt = 24'h0000;
        oc_woke_nxt = 1'b0;
        wake_nxt = 1'b0;
        if (lp_oc && oc_s) begin
            oc_woke_nxt = oc_woke_r;
            oc_cnt_nxt = oc_cnt_r;
            if (!oc_woke_r && oc_cnt_r >= (oc_sel[0] ? overcurrent_wake_time_in : OC_LAST)) begin
                wake_nxt = 1'b1;
                oc_woke_nxt = 1'b1;
            end else if (!oc_woke_r) begin
                oc_cnt_nxt = oc_cnt_r + 24'h0001;
            end
        end
        // reset pulse sequencer
        st_nxt = st_r;
        rcnt_nxt = 16'h0000;
        strike_nxt = refresh_done ? 1'b0 : strike_r;
        safe_n_nxt = safe_n_r;
        case (st_r)
            RS_RUN: begin
                if (fail) begin
                    st_nxt = RS_PULSE;
                    strike_nxt = 1'b1;
                    if (!cfg_r[B_SAFE] || strike_r) begin
                        safe_n_nxt = 1'b0;
                    end
                end
            end
            RS_PULSE: begin
                rcnt_nxt = rcnt_r + 16'h0001;
                if (rcnt_r == RST_LAST) begin
                    st_nxt = RS_RUN;
                    rcnt_nxt = 16'h0000;
                end
            end
            default: st_nxt = RS_RUN;
        endcase
        rst_n_nxt = !(st_nxt == RS_PULSE || crank_rst);
        vdd_en_nxt = !crank_rst;
    end

    // registers; safe output stays low until the next system reset
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            sync1_r <= 2'h0;
            sync2_r <= 2'h0;
            cfg_r <= CFG_RESET;
            lfsr_r <= LFSR_SEED;
            code_r <= LFSR_SEED;
            per_cnt_r <= 24'h0000;
            seq_r <= 2'h0;
            irq_pend_r <= 1'b0;
            irq_ends_r <= 2'h0;
            oc_cnt_r <= 24'h0000;
            oc_woke_r <= 1'b0;
            st_r <= RS_RUN;
            rcnt_r <= 16'h0000;
            strike_r <= 1'b0;
            safe_n_r <= 1'b1;
            rst_n_r <= 1'b1;
            vdd_en_r <= 1'b1;
            wake_r <= 1'b0;
        end else begin
            sync1_r <= {supply_low_in, overcurrent_in};
            sync2_r <= sync1_r;
            cfg_r <= cfg_nxt;
            lfsr_r <= lfsr_nxt;
            code_r <= code_nxt;
            per_cnt_r <= per_cnt_nxt;
            seq_r <= seq_nxt;
            irq_pend_r <= irq_pend_nxt;
            irq_ends_r <= irq_ends_nxt;
            oc_cnt_r <= oc_cnt_nxt;
            oc_woke_r <= oc_woke_nxt;
            st_r <= st_nxt;
            rcnt_r <= rcnt_nxt;
            strike_r <= strike_nxt;
            safe_n_r <= safe_n_nxt;
            rst_n_r <= rst_n_nxt;
            vdd_en_r <= vdd_en_nxt;
            wake_r <= wake_nxt;
        end
    end

    assign cfg_out = cfg_r;
    assign random_code_out = code_r;
    assign rst_n_out = rst_n_r;
    assign safe_n_out = safe_n_r;
    assign vdd_en_out = vdd_en_r;
    assign wake_out = wake_r;

    // checks
    property p_cfg_locked;
        @(posedge clk_in) disable iff (sys_rst_in) !init_mode_in |=> $stable(cfg_r);
    endproperty
    a_cfg_locked: assert property (p_cfg_locked) else $error("config changed outside init");
    property p_cfg_write;
        @(posedge clk_in) disable iff (sys_rst_in) wr_cfg |=> cfg_r == $past(frame_data_in[7:0]);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write lost");
    property p_no_deadline;
        @(posedge clk_in) disable iff (sys_rst_in) !cfg_r[B_DEADLINE] && st_r == RS_RUN
            && !bad && !timeout |=> st_r == RS_RUN;
    endproperty
    a_no_deadline: assert property (p_no_deadline) else $error("reset without cause");
    property p_deadline;
        @(posedge clk_in) disable iff (sys_rst_in) deadline_fail && st_r == RS_RUN
            |=> st_r == RS_PULSE && !rst_n_out;
    endproperty
    a_deadline: assert property (p_deadline) else $error("missed read gave no reset");
    property p_oc_ignored;
        @(posedge clk_in) disable iff (sys_rst_in) !oc_sel[1] |=> !wake_out;
    endproperty
    a_oc_ignored: assert property (p_oc_ignored) else $error("wake with overcurrent ignored");
    property p_oc_filter;
        @(posedge clk_in) disable iff (sys_rst_in) $rose(wake_out) && $past(oc_sel) == 2'b10
            |-> $past(oc_cnt_r) == OC_LAST;
    endproperty
    a_oc_filter: assert property (p_oc_filter) else $error("wake at wrong filter count");
    property p_safe_first;
        @(posedge clk_in) disable iff (sys_rst_in) fail && st_r == RS_RUN && !cfg_r[B_SAFE]
            |=> !safe_n_out && !rst_n_out;
    endproperty
    a_safe_first: assert property (p_safe_first) else $error("safe not low with first reset");
    property p_safe_second;
        @(posedge clk_in) disable iff (sys_rst_in) fail && st_r == RS_RUN && cfg_r[B_SAFE]
            && !strike_r && safe_n_r |=> safe_n_out && !rst_n_out;
    endproperty
    a_safe_second: assert property (p_safe_second) else $error("safe low on first reset");
    property p_early;
        @(posedge clk_in) disable iff (sys_rst_in) rf && wd_active && cfg_r[B_WINDOW]
            && per_cnt_r < PER_HALF |=> st_r == RS_PULSE;
    endproperty
    a_early: assert property (p_early) else $error("early refresh accepted");
    property p_crank;
        @(posedge clk_in) disable iff (sys_rst_in) vlow_s |=> vdd_en_out == $past(cfg_r[B_CRANK]);
    endproperty
    a_crank: assert property (p_crank) else $error("regulator wrong on low supply");
    c_refresh: cover property (@(posedge clk_in) disable iff (sys_rst_in) refresh_done && scheme == SCH_FOUR);
    c_timeout: cover property (@(posedge clk_in) disable iff (sys_rst_in) timeout);
    c_safe: cover property (@(posedge clk_in) disable iff (sys_rst_in) $fell(safe_n_out) && cfg_r[B_SAFE]);
endmodule : sbcwd_core

// *** tb/sbcwd_mcu_model.sv ***
/*
 * sbcwd_mcu_model: microcontroller side, hands whole SPI frames to the block.
 * Assumes the block samples one-cycle frame strobes on rising edges of clk_in.
 */
`timescale 1ns/1ps
module sbcwd_mcu_model (
    input wire logic clk_in,
    output logic frame_valid_out,
    output logic frame_len16_out,
    output logic [15:0] frame_data_out
);
    // idle lines at time zero
    initial begin
        frame_valid_out = 1'b0;
        frame_len16_out = 1'b1;
        frame_data_out = 16'h0000;
    end

    // one frame: header, odd parity over the word (flipped when bad), data byte
    task send(input logic len16, input logic bad, input logic [6:0] hdr, input logic [7:0] dat);
        @(posedge clk_in);
        frame_valid_out <= 1'b1;
        frame_len16_out <= len16;
        frame_data_out <= {hdr, bad ^ ~^{hdr, dat}, dat};
        @(posedge clk_in);
        frame_valid_out <= 1'b0;
        // released lines show the inverse so stale data never looks valid
        frame_data_out <= ~frame_data_out;
    endtask : send
endmodule : sbcwd_mcu_model

// *** tb/sbc_watchdog_init_config_test.sv ***
/*
 * sbc_watchdog_init_config_test: self-checking bench for sbcwd_core.
 * Assumes shortened counts: period 64, overcurrent filter 20, reset pulse 4.
 */
`timescale 1ns/1ps
module sbc_watchdog_init_config_test;
    import sbcwd_pkg::*;
    localparam int PER = 64;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic init_m = 1'b1, lp_m = 1'b0, wd_lp = 1'b0, oc = 1'b0, sup_low = 1'b0;
    logic irq_ev = 1'b0, irq_rd = 1'b0;
    logic fv, f16;
    logic [15:0] fd;
    logic [7:0] cfg, code, c0;
    logic rst_n, safe_n, vdd_en, wake;
    int bad_count = 0;
    int compares = 0;
    int n;

    sbcwd_core #(.WD_PERIOD(PER), .OC_FILT(20), .RST_PULSE(4)) i_dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .frame_valid_in(fv),
        .frame_len16_in(f16), .frame_data_in(fd), .parity_en_in(1'b1),
        .init_mode_in(init_m), .low_power_regulator_on_mode_in(lp_m), .wd_in_lp_in(wd_lp),
        .overcurrent_in(oc), .supply_low_in(sup_low), .overcurrent_wake_time_in(24'h00_0009),
        .irq_event_in(irq_ev), .irq_read_in(irq_rd), .cfg_out(cfg), .random_code_out(code),
        .rst_n_out(rst_n), .safe_n_out(safe_n), .vdd_en_out(vdd_en), .wake_out(wake));

    sbcwd_mcu_model i_mcu (.clk_in(clk_in), .frame_valid_out(fv), .frame_len16_out(f16),
        .frame_data_out(fd));

    // 200 MHz clock
    initial begin
        forever #2.5 clk_in = ~clk_in;
    end

    task check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task tick(input int k);
        repeat (k) @(posedge clk_in);
    endtask : tick

    // bounded wait for the reset output to reach lvl; n keeps the cycles taken
    task wait_rst(input logic lvl, input int max);
        n = 0;
        // step off the edge so a level launched there is settled
        #1;
        while (rst_n !== lvl && n < max) begin
            tick(1);
            #1;
            n++;
        end
    endtask : wait_rst

    // system reset per scenario, since the fail-safe latch clears only there
    task restart(input logic [7:0] c);
        @(posedge clk_in);
        sys_rst_in <= 1'b1;
        init_m <= 1'b1;
        tick(3);
        sys_rst_in <= 1'b0;
        i_mcu.send(1'b1, 1'b0, {WR_ACCESS, CFG_ADDR}, c);
        tick(1);
        init_m <= 1'b0;
        #1;
        check(cfg, c);
    endtask : restart

    task t_refuse;
        i_mcu.send(1'b1, 1'b1, {WR_ACCESS, CFG_ADDR}, 8'h00);
        tick(2);
        init_m <= 1'b0;
        i_mcu.send(1'b1, 1'b0, {WR_ACCESS, CFG_ADDR}, 8'h00);
        tick(1);
        #1;
        check(cfg, 8'h42);
    endtask : t_refuse

    task t_window;
        restart(8'h02);
        i_mcu.send(1'b0, 1'b0, REFRESH_HDR, 8'h00);
        wait_rst(1'b0, 4);
        check({6'h0, rst_n, safe_n}, 8'h00);
        restart(8'h02);
        tick(40);
        i_mcu.send(1'b0, 1'b0, REFRESH_HDR, 8'h00);
        wait_rst(1'b0, 50);
        check({7'h0, rst_n}, 8'h01);
    endtask : t_window

    // coded refresh of 1, 2 or 4 frames carrying code xor index; bad spoils the last
    task coded(input logic [1:0] s, input logic bad);
        int cnt;
        cnt = 1 << (s - 2'd1);
        restart({4'h0, s, 2'h0});
        c0 = code;
        for (int k = 0; k < cnt; k++) begin
            i_mcu.send(1'b1, 1'b0, REFRESH_HDR, c0 ^ k[7:0] ^ {7'h0, bad && k == cnt - 1});
        end
        wait_rst(1'b0, 4);
        check({6'h0, rst_n, code != c0}, bad ? 8'h00 : 8'h03);
    endtask : coded

    task t_safe;
        restart(8'h10);
        repeat (3) begin
            tick(40);
            i_mcu.send(1'b0, 1'b0, REFRESH_HDR, 8'h00);
        end
        wait_rst(1'b0, PER + 8);
        check({6'h0, n > 50, rst_n}, 8'h02);
        check({7'h0, safe_n}, 8'h01);
        wait_rst(1'b1, 8);
        wait_rst(1'b0, PER + 8);
        tick(1);
        #1;
        check({6'h0, rst_n, safe_n}, 8'h00);
    endtask : t_safe

    task crank(input logic [7:0] c, input logic [7:0] exp);
        restart(c);
        tick(1);
        sup_low <= 1'b1;
        tick(6);
        #1;
        check({6'h0, vdd_en, rst_n}, exp);
        tick(1);
        sup_low <= 1'b0;
    endtask : crank

    // overcurrent held in low-power mode; n is the cycle of the first wake, 99 if none
    task oc_run(input logic [7:0] c, input logic wd, input int lo, input int hi);
        restart(c);
        tick(1);
        lp_m <= 1'b1;
        wd_lp <= wd;
        oc <= 1'b1;
        n = 99;
        for (int k = 1; k < 60; k++) begin
            tick(1);
            #1;
            if (wake === 1'b1 && n == 99) n = k;
        end
        tick(1);
        oc <= 1'b0;
        lp_m <= 1'b0;
        wd_lp <= 1'b0;
        check({7'h0, n >= lo && n <= hi}, 8'h01);
    endtask : oc_run

    // one interrupt, read late or never, while refreshes keep the watchdog fed
    task t_deadline(input logic [7:0] c, input logic rd, input logic [7:0] exp);
        restart(c);
        tick(1);
        irq_ev <= 1'b1;
        tick(1);
        irq_ev <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            irq_rd <= rd && k == 2;
            tick(1);
            irq_rd <= 1'b0;
            tick(29);
            i_mcu.send(1'b0, 1'b0, REFRESH_HDR, 8'h00);
        end
        wait_rst(1'b0, 4);
        check({7'h0, rst_n}, exp);
    endtask : t_deadline

    // short overcurrent pulses in low-power mode must keep the watchdog fed
    task t_oc_refresh;
        restart(8'h60);
        tick(1);
        lp_m <= 1'b1;
        wd_lp <= 1'b1;
        repeat (4) begin
            oc <= 1'b1;
            tick(4);
            oc <= 1'b0;
            wait_rst(1'b0, 30);
            check({6'h0, rst_n, wake}, 8'h02);
            tick(1);
        end
        lp_m <= 1'b0;
        wd_lp <= 1'b0;
    endtask : t_oc_refresh

    task stop_test;
        $display("comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    // watchdog: the whole run needs well under 5000 cycles
    initial begin
        tick(20000);
        bad_count++;
        stop_test();
    end

    // main sequence
    initial begin
        tick(3);
        sys_rst_in <= 1'b0;
        tick(1);
        #1;
        check(cfg, 8'h42);
        check(code, LFSR_SEED);
        check({4'h0, rst_n, safe_n, vdd_en, wake}, 8'h0e);
        t_refuse();
        t_window();
        coded(2'd1, 1'b0);
        coded(2'd2, 1'b0);
        coded(2'd3, 1'b0);
        coded(2'd3, 1'b1);
        coded(2'd1, 1'b1);
        t_safe();
        crank(8'h42, 8'h00);
        crank(8'h43, 8'h03);
        oc_run(8'h00, 1'b0, 99, 99);
        oc_run(8'h20, 1'b0, 99, 99);
        oc_run(8'h40, 1'b0, 20, 25);
        oc_run(8'h60, 1'b0, 10, 15);
        oc_run(8'h20, 1'b1, 99, 99);
        oc_run(8'h40, 1'b1, 20, 25);
        oc_run(8'h60, 1'b1, 10, 15);
        t_deadline(8'h00, 1'b0, 8'h01);
        t_deadline(8'h80, 1'b0, 8'h00);
        t_deadline(8'h80, 1'b1, 8'h01);
        t_oc_refresh();
        stop_test();
    end
endmodule : sbc_watchdog_init_config_test
